// ===== tb/sfp_flash_pins_props.sv
// ========
// Pin and request checks
module sfp_flash_pins_props (
	input wire logic                  i_clock,
	input wire logic                  i_sys_rst,
	input wire sfp_pkg::sfp_pins_t    i_pins,
	input wire logic [3:0]            o_lane_out,
	input wire logic [3:0]            o_lane_oe_n,
	input wire sfp_pkg::sfp_req_t     o_req_r,
	input wire sfp_pkg::sfp_prog_t    o_prog_r,
	input wire sfp_pkg::sfp_reg_req_t i_reg,
	input wire logic [31:0]           o_reg_rdata_r
);
	import sfp_pkg::*;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	desel_float_a: assert property ($past(i_pins.sel_n) |-> o_lane_oe_n == 4'hF)
		else $error("lanes driven while deselected");
	lane_sets_a: assert property (o_lane_oe_n inside {4'hF, 4'hD, 4'hC, 4'h0})
		else $error("illegal lane drive set");
	out_fall_a: assert property (!o_lane_oe_n[1] && $past(!o_lane_oe_n[1])
		&& $changed(o_lane_out[1]) |-> !$past(i_pins.sclk) && $past(i_pins.sclk, 2))
		else $error("lane one changed off a falling edge");
	pause_float_a: assert property ($past(!i_pins.lanes[3] && !i_pins.sel_n) && o_lane_oe_n[3]
		|-> o_lane_oe_n == 4'hF) else $error("lanes driven during pause");
	rdata_idle_a: assert property (!$past(i_reg.rd) |-> o_reg_rdata_r == 32'h0)
		else $error("read data outside its cycle");
	req_pulse_a: assert property (o_req_r.valid |=> !o_req_r.valid)
		else $error("request longer than a pulse");
	req_commit_a: assert property (o_req_r.valid |-> $past(i_pins.sel_n))
		else $error("request while selected");
	prog_count_a: assert property (o_req_r.valid && o_req_r.op == OP_PROG
		|-> o_req_r.count inside {[9'h001:9'h100]}) else $error("program count out of range");
	prog_rise_a: assert property (o_prog_r.valid
		|-> $past(i_pins.sclk) && !$past(i_pins.sclk, 2) && !$past(i_pins.sel_n))
		else $error("program byte off a rising edge");
endmodule : sfp_flash_pins_props

// ===== tb/sfp_flash_pins_tb.sv
module sfp_flash_pins_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sfp_pkg::*;
	logic         clk, rst, busy, tog, sclk, sel_n;
	logic [3:0]   lout, loe_n, hdrv, hoe, lanes;
	logic [23:0]  raddr;
	logic [31:0]  rdata, g;
	sfp_pins_t    pins;
	sfp_req_t     req, req_q;
	sfp_prog_t    prog;
	sfp_reg_req_t rq;
	int           num_errors, checks, nreq;
	logic [31:0]  pq[$];
	// Released lanes toggle so stale values never pass
	assign lanes = (~loe_n & lout) | (loe_n & hoe & hdrv) | (loe_n & ~hoe & {4{tog}});
	assign pins = {sclk, sel_n, lanes};
	sfp_flash_pins #(.PAGE_BYTES(256)) dut_u (.i_clock(clk), .i_sys_rst(rst), .i_pins(pins),
		.o_lane_out(lout), .o_lane_oe_n(loe_n), .i_rd_data(raddr[7:0] ^ 8'hA5),
		.o_rd_addr_r(raddr), .i_core_busy(busy), .o_req_r(req), .o_prog_r(prog),
		.i_reg(rq), .o_reg_rdata_r(rdata));
	sfp_host_model hm_u (.i_clock(clk), .i_lanes(lanes), .o_sclk(sclk), .o_sel_n(sel_n),
		.o_drv(hdrv), .o_hoe(hoe));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	// Capture requests and program bytes
	always @(posedge clk) begin
		tog <= ~tog;
		if (req.valid) begin
			req_q <= req;
			nreq <= nreq + 1;
		end
		if (prog.valid) pq.push_back({prog.addr, prog.data});
	end
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic reg_io(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		rq <= '{wr, ~wr, a, d};
		@(posedge clk);
		rq <= '0;
		#1 g = rdata;
	endtask : reg_io
	task automatic send(input logic m3, input logic [7:0] op);
		hm_u.open(m3);
		hm_u.bits(1, 8, 0, {op, 24'h0}, g);
	endtask : send
	task automatic latch();
		send(0, OPC_LATCH_SET);
		hm_u.close();
	endtask : latch
	task automatic sread();
		send(0, OPC_STAT_READ);
		hm_u.bits(1, 8, 1, 0, g);
		hm_u.close();
	endtask : sread
	task automatic swrite(input logic [7:0] b);
		latch();
		send(0, OPC_STAT_WRITE);
		hm_u.bits(1, 8, 0, {b, 24'h0}, g);
		hm_u.close();
	endtask : swrite
	// ========
	// Scenarios
	task automatic t_select();
		hm_u.bits(1, 8, 0, {OPC_LATCH_SET, 24'h0}, g);
		hm_u.close();
		reg_io(0, REG_STATUS, 0);
		cmp("latch before select fall", 0, g[11:0]);
		latch();
		busy <= 1;
		sread();
		cmp("serial status", 32'h3, g);
		busy <= 0;
		$display("select test done");
	endtask : t_select
	task automatic t_erase();
		logic [7:0]  ops[4] = '{OPC_SECT_ERASE, OPC_HALF_ERASE, OPC_BLOCK_ERASE, OPC_CHIP_ERASE};
		logic [23:0] msk[3] = '{SECT_MASK, HALF_MASK, BLOCK_MASK};
		int          n;
		for (int i = 0; i < 4; i++) begin
			n = nreq;
			latch();
			send(i[0], ops[i]);
			if (i < 3) hm_u.bits(1, 24, 0, {24'h03_5A7C, 8'h0}, g);
			hm_u.close();
			cmp("erase count", n + 1, nreq);
			cmp("erase kind", i + 2, req_q.op);
			if (i < 3) cmp("erase address", 24'h03_5A7C & ~msk[i], req_q.addr);
		end
		$display("erase test done");
	endtask : t_erase
	task automatic t_program();
		latch();
		pq.delete();
		send(0, OPC_PAGE_PROG);
		hm_u.bits(1, 24, 0, {24'h00_00FF, 8'h0}, g);
		hm_u.bits(1, 16, 0, 32'hA15C_0000, g);
		hm_u.close();
		cmp("program request", {OP_PROG, 9'h002}, {req_q.op, req_q.count});
		cmp("program address", 24'h00_00FF, req_q.addr);
		cmp("first byte", 32'h0000_FFA1, pq[0]);
		cmp("wrapped byte", 32'h0000_005C, pq[1]);
		$display("program test done");
	endtask : t_program
	task automatic t_lanes();
		reg_io(1, REG_DUMMY, 2);
		reg_io(0, REG_DUMMY, 0);
		cmp("dummy count", 2, g);
		send(0, OPC_DUAL_IO_RD);
		hm_u.bits(2, 12, 0, {24'h01_2345, 8'h0}, g);
		hm_u.bits(2, 2, 0, 0, g);
		hm_u.bits(2, 4, 1, 0, g);
		hm_u.close();
		cmp("dual read", 8'h45 ^ 8'hA5, g);
		send(0, OPC_QUAD_IO_RD);
		hm_u.bits(4, 6, 0, {24'h01_2366, 8'h0}, g);
		hm_u.bits(4, 2, 0, 0, g);
		hm_u.bits(4, 2, 1, 0, g);
		hm_u.close();
		cmp("quad read", 8'h66 ^ 8'hA5, g);
		$display("lane test done");
	endtask : t_lanes
	task automatic t_pause();
		logic [3:0] hi;
		send(0, OPC_READ);
		hm_u.bits(1, 24, 0, {24'h00_0010, 8'h0}, g);
		hm_u.bits(1, 4, 1, 0, g);
		hi = g[3:0];
		hm_u.pin(3, 0);
		hm_u.wt(6);
		cmp("lanes in pause", 4'hF, loe_n);
		hm_u.pin(3, 1);
		hm_u.wt(1);
		hm_u.bits(1, 4, 1, 0, g);
		hm_u.close();
		cmp("paused read", 8'h10 ^ 8'hA5, {hi, g[3:0]});
		$display("pause test done");
	endtask : t_pause
	task automatic t_guard();
		swrite(8'hBC);
		sread();
		cmp("locked status", 8'hBC, g);
		hm_u.pin(2, 0);
		swrite(8'h00);
		sread();
		cmp("guarded status", 8'hBC, g & 32'hFC);
		hm_u.pin(2, 1);
		swrite(8'h00);
		sread();
		cmp("released status", 0, g);
		$display("guard test done");
	endtask : t_guard
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		rst = 1; busy = 0; rq = '0; tog = 0; nreq = 0; num_errors = 0; checks = 0;
		repeat (20) @(posedge clk);
		rst <= 0;
		t_select(); t_erase(); t_program(); t_lanes(); t_pause(); t_guard();
		report_and_stop();
	end
	// Hang guard
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end
endmodule : sfp_flash_pins_tb
bind sfp_flash_pins sfp_flash_pins_props u_props (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
	.i_pins(i_pins), .o_lane_out(o_lane_out), .o_lane_oe_n(o_lane_oe_n), .o_req_r(o_req_r),
	.o_prog_r(o_prog_r), .i_reg(i_reg), .o_reg_rdata_r(o_reg_rdata_r));

// ===== tb/sfp_host_model.sv
// ========
// Host controller driving clock, select and lanes
module sfp_host_model (
	input  wire logic [3:0] i_lanes,
	input  wire logic       i_clock,
	output logic            o_sclk,
	output logic            o_sel_n,
	output logic [3:0]      o_drv,
	output logic [3:0]      o_hoe
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 4; // Clock half period in system cycles
	logic       idle;        // Clock idle level
	logic [3:0] idle_d;      // Guard and pause levels
	// Select low at power-up is not a select fall
	initial begin
		o_sclk = 0; o_sel_n = 0; o_drv = 4'hC; o_hoe = 4'hC; idle = 0; idle_d = 4'hC;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge i_clock);
	endtask : wt
	task automatic pin(input int k, input logic b);
		@(posedge i_clock);
		idle_d[k] = b;
		o_drv[k] <= b;
	endtask : pin
	task automatic open(input logic m3);
		wt(1);
		idle = m3;
		o_sclk <= m3; // Idle level picks the mode
		wt(3);
		o_sel_n <= 1'b0; // Fresh select fall
		wt(HALF);
	endtask : open
	// Falls launch host data, rises sample device data
	task automatic bits(input int w, input int n, input logic rd, input logic [31:0] v,
		output logic [31:0] got);
		logic [3:0] d;
		got = 0;
		for (int i = 0; i < n; i++) begin
			d = idle_d;
			for (int j = w - 1; j >= 0; j--) begin
				d[j] = v[31]; // Top bit first
				v = v << 1;
			end
			o_sclk <= 1'b0;
			o_hoe <= rd ? (w == 4 ? 4'h0 : 4'hC) : (w == 1 ? 4'hD : 4'hF);
			o_drv <= d;
			wt(HALF);
			o_sclk <= 1'b1;
			for (int j = w - 1; j >= 0; j--) got = {got[30:0], i_lanes[w == 1 ? 1 : j]};
			wt(HALF);
		end
	endtask : bits
	task automatic close();
		wt(HALF);
		o_sclk <= idle;
		wt(HALF);
		o_sel_n <= 1'b1;
		o_hoe <= 4'hC;
		o_drv <= idle_d;
		wt(6);
	endtask : close
endmodule : sfp_host_model

// ===== verilog/sfp_flash_pins.sv
// Contract
// - Single lane: sample input on clock rise
// - Single lane: drive output on clock fall
// - Multi lane: host writes rise, device reads fall
// - Lanes 0-1 dual and quad; 2-3 quad
// - Select high: all data pins float
// - Select low: accept instructions, return data
// - Ignore instructions until first select fall
// - Pause low: float output, ignore clock, input
// - Pause in single/dual; lane three in quad
// - Write guard blocks status writes with lock
// - Four range protect bits in status
// - Write guard single/dual; lane two in quad
// - Clock modes zero and three both work
// - Page program takes 1 to 256 bytes
// - Erase sector, half block, block, chip
// - Status shows operation pending bit
// - Dual lanes only for 3Bh and BBh
module sfp_flash_pins #(
	parameter int PAGE_BYTES = 256
) (
	input  wire logic                 i_clock,
	input  wire logic                 i_sys_rst,
	input  wire sfp_pkg::sfp_pins_t   i_pins,
	output logic [3:0]                o_lane_out,
	output logic [3:0]                o_lane_oe_n,
	input  wire logic [7:0]           i_rd_data,
	output logic [23:0]               o_rd_addr_r,
	input  wire logic                 i_core_busy,
	output sfp_pkg::sfp_req_t         o_req_r,
	output sfp_pkg::sfp_prog_t        o_prog_r,
	input  wire sfp_pkg::sfp_reg_req_t i_reg,
	output logic [31:0]               o_reg_rdata_r
);
	import sfp_pkg::*;

	// ============================================================
	// Elaboration check
	localparam int         PW       = $clog2(PAGE_BYTES);
	localparam logic [8:0] PAGE_MAX = 9'(PAGE_BYTES);
	generate
		if (PAGE_BYTES < 2 || PAGE_BYTES > 256 || (PAGE_BYTES & (PAGE_BYTES - 1)) != 0) begin : g_bad
			$error("PAGE_BYTES must be a power of two from 2 to 256");
		end
	endgenerate

	// ============================================================
	// Decoded instruction
	typedef struct packed {
		sfp_state_t  next;   // State after the opcode
		sfp_lane_w_t addr_w; // Lane width for address
		sfp_lane_w_t data_w; // Lane width for read data
		logic        quad;   // Pause and guard pins become lanes
	} sfp_dec_t;

	function automatic sfp_dec_t decode(input logic [7:0] opc);
		decode = '{ST_IGNORE, LW_ONE, LW_ONE, 1'b0};
		unique case (opc)
			OPC_LATCH_SET, OPC_CHIP_ERASE: decode.next = ST_TAIL;
			OPC_STAT_READ:  decode.next = ST_STAT;
			OPC_STAT_WRITE: decode.next = ST_SRDATA;
			OPC_READ, OPC_FAST_READ, OPC_PAGE_PROG,
			OPC_SECT_ERASE, OPC_HALF_ERASE, OPC_BLOCK_ERASE: decode.next = ST_ADDR;
			OPC_DUAL_OUT_RD: decode = '{ST_ADDR, LW_ONE, LW_TWO, 1'b0};
			OPC_DUAL_IO_RD:  decode = '{ST_ADDR, LW_TWO, LW_TWO, 1'b0};
			OPC_QUAD_IO_RD:  decode = '{ST_ADDR, LW_FOUR, LW_FOUR, 1'b1};
			default: ;
		endcase
	endfunction : decode

	// Shift lanes into a byte, most significant bit first
	function automatic logic [7:0] shift_in(input logic [7:0] b, input logic [3:0] l,
	                                        input sfp_lane_w_t w);
		unique case (w)
			LW_TWO:  shift_in = {b[5:0], l[1:0]};
			LW_FOUR: shift_in = {b[3:0], l};
			default: shift_in = {b[6:0], l[0]};
		endcase
	endfunction : shift_in

	// ============================================================
	// State
	sfp_state_t  state_r, state_nxt;     // Transfer phase
	sfp_lane_w_t lw_r, lw_nxt;           // Receive lane width
	sfp_lane_w_t txw_r, txw_nxt;         // Transmit lane width
	logic        quad_r, quad_nxt;       // Quad instruction running
	logic        armed_r;                // Select has fallen since reset
	logic [3:0]  bit_r, bit_nxt;         // Bits of current byte
	logic [1:0]  acnt_r, acnt_nxt;       // Address bytes taken
	logic [23:0] addr_r, addr_nxt;       // Assembled address
	logic [7:0]  rx_r, rx_nxt;           // Receive shift register
	logic [7:0]  cmd_r, cmd_nxt;         // Current opcode
	logic [3:0]  dcnt_r, dcnt_nxt;       // Dummy clocks seen
	logic [8:0]  pcnt_r, pcnt_nxt;       // Program bytes accepted
	logic [7:0]  sr_byte_r, sr_byte_nxt; // Status byte written by host
	logic        srok_r, srok_nxt;       // Status byte complete
	logic        latch_r, latch_nxt;     // Write latch
	logic [3:0]  prot_r, prot_nxt;       // range_protect_bit0..3
	logic        lock_r, lock_nxt;       // status_lock
	logic [3:0]  dummy_r;                // Dummy clocks for fast reads
	logic [23:0] rd_addr_nxt;            // Next read address
	sfp_req_t    req_nxt;                // Next core request
	sfp_prog_t   prog_nxt;               // Next program byte

	// ============================================================
	// Pin qualification
	logic       rise, fall, sel_fall, sel_rise;
	logic       paused;    // Pause pin low in single or dual
	logic       guard_on;  // Write guard pin low in single or dual
	logic       selected;  // Selected and armed
	logic       rise_act;  // Rising edge that counts
	logic       rx_phase;  // States that sample lanes
	logic [3:0] step;      // Bits per rising edge
	logic [7:0] rx_in;     // Byte after this edge
	sfp_dec_t   dec;       // Decode of rx_in
	logic       byte_done; // Byte completes on this edge
	logic       commit;    // Deselect on a whole byte
	logic       sr_blocked;
	logic       pending;
	logic       tx_run, tx_take;
	logic [7:0] tx_byte, status_byte;
	logic [PW-1:0] page_off;
	logic [23:0] new_addr;

	sfp_pin_edge u_edge (
		.i_clock     (i_clock),
		.i_sys_rst   (i_sys_rst),
		.i_sclk      (i_pins.sclk),
		.i_sel_n     (i_pins.sel_n),
		.o_sclk_rise (rise),
		.o_sclk_fall (fall),
		.o_sel_fall  (sel_fall),
		.o_sel_rise  (sel_rise)
	);

	assign paused     = ~i_pins.sel_n & ~quad_r & ~i_pins.lanes[3];
	assign guard_on   = ~quad_r & ~i_pins.lanes[2];
	assign sr_blocked = lock_r & guard_on;
	assign selected   = ~i_pins.sel_n & armed_r;
	assign rise_act   = rise & selected & ~paused;
	assign rx_phase   = (state_r == ST_CMD) || (state_r == ST_ADDR) || (state_r == ST_WDATA)
	                    || (state_r == ST_SRDATA) || (state_r == ST_TAIL);
	assign step       = lane_step(lw_r);
	assign rx_in      = shift_in(rx_r, i_pins.lanes, lw_r);
	assign dec        = decode(rx_in);
	assign byte_done  = (bit_r + step) == 4'h8;
	assign commit     = sel_rise & armed_r & (bit_r == 4'h0);
	assign pending    = i_core_busy | o_req_r.valid;
	assign new_addr   = {addr_r[15:0], rx_in};
	assign page_off   = addr_r[PW-1:0] + pcnt_r[PW-1:0];

	// Status byte
	always_comb begin
		status_byte                        = 8'h00;
		status_byte[SB_PENDING]            = pending;
		status_byte[SB_LATCH]              = latch_r;
		status_byte[SB_PROT_LO +: 4]       = prot_r;
		status_byte[SB_LOCK]               = lock_r;
	end

	// ============================================================
	// Transmit path
	assign tx_run  = selected & ~paused & ((state_r == ST_RDATA) || (state_r == ST_STAT));
	assign tx_byte = (state_r == ST_STAT) ? status_byte : i_rd_data;

	sfp_tx_shift u_tx (
		.i_clock       (i_clock),
		.i_sys_rst     (i_sys_rst),
		.i_clear       (i_pins.sel_n),
		.i_fall        (fall),
		.i_run         (tx_run),
		.i_width       (txw_r),
		.i_byte        (tx_byte),
		.o_take        (tx_take),
		.o_lane_out_r  (o_lane_out),
		.o_lane_oe_n_r (o_lane_oe_n)
	);

	// ============================================================
	// Transfer sequencing
	always_comb begin
		state_nxt   = state_r;
		lw_nxt      = lw_r;
		txw_nxt     = txw_r;
		quad_nxt    = quad_r;
		bit_nxt     = bit_r;
		acnt_nxt    = acnt_r;
		addr_nxt    = addr_r;
		rx_nxt      = rx_r;
		cmd_nxt     = cmd_r;
		dcnt_nxt    = dcnt_r;
		pcnt_nxt    = pcnt_r;
		sr_byte_nxt = sr_byte_r;
		srok_nxt    = srok_r;
		rd_addr_nxt = o_rd_addr_r;
		prog_nxt    = '0;
		if (i_pins.sel_n) begin
			// Idle between transfers
			state_nxt = ST_CMD;
			lw_nxt    = LW_ONE;
			txw_nxt   = LW_ONE;
			quad_nxt  = 1'b0;
			bit_nxt   = 4'h0;
			acnt_nxt  = 2'h0;
			dcnt_nxt  = 4'h0;
			pcnt_nxt  = 9'h000;
			srok_nxt  = 1'b0;
		end else if (rise_act && state_r == ST_DUMMY) begin
			// Count dummy clocks, then hand lanes to read data
			dcnt_nxt = dcnt_r + 4'h1;
			if (dcnt_r + 4'h1 >= dummy_r) begin
				state_nxt = ST_RDATA;
			end
		end else if (rise_act && rx_phase) begin
			rx_nxt  = rx_in;
			bit_nxt = byte_done ? 4'h0 : bit_r + step;
			if (byte_done) begin
				unique case (state_r)
					ST_CMD: begin
						cmd_nxt   = rx_in;
						state_nxt = dec.next;
						lw_nxt    = dec.addr_w;
						txw_nxt   = dec.data_w;
						quad_nxt  = dec.quad;
					end
					ST_ADDR: begin
						addr_nxt = new_addr;
						acnt_nxt = acnt_r + 2'h1;
						if (acnt_r == 2'h2) begin
							rd_addr_nxt = new_addr;
							if (cmd_r == OPC_PAGE_PROG) begin
								state_nxt = ST_WDATA;
							end else if (cmd_r == OPC_SECT_ERASE || cmd_r == OPC_HALF_ERASE
							             || cmd_r == OPC_BLOCK_ERASE) begin
								state_nxt = ST_TAIL;
							end else if (cmd_r == OPC_READ || dummy_r == 4'h0) begin
								state_nxt = ST_RDATA;
							end else begin
								state_nxt = ST_DUMMY;
							end
						end
					end
					ST_WDATA: begin
						// Stream bytes, wrapping inside the page
						if (latch_r && !pending) begin
							prog_nxt.valid = 1'b1;
							prog_nxt.addr  = {addr_r[23:PW], page_off};
							prog_nxt.data  = rx_in;
						end
						if (pcnt_r != PAGE_MAX) begin
							pcnt_nxt = pcnt_r + 9'h001;
						end
					end
					ST_SRDATA: begin
						sr_byte_nxt = rx_in;
						srok_nxt    = 1'b1;
						state_nxt   = ST_TAIL;
					end
					ST_TAIL: state_nxt = ST_IGNORE;
					default: ;
				endcase
			end
		end
		if (tx_take && state_r == ST_RDATA) begin
			rd_addr_nxt = o_rd_addr_r + 24'h00_0001;
		end
	end

	// ============================================================
	// Commit at deselect
	always_comb begin
		latch_nxt = latch_r;
		prot_nxt  = prot_r;
		lock_nxt  = lock_r;
		req_nxt   = '0;
		if (commit && state_r == ST_TAIL && cmd_r == OPC_LATCH_SET) begin
			latch_nxt = 1'b1;
		end else if (commit && state_r == ST_TAIL && latch_r && !pending) begin
			// Host has set the latch first
			unique case (cmd_r)
				OPC_STAT_WRITE: begin
					if (srok_r && !sr_blocked) begin
						prot_nxt  = sr_byte_r[SB_PROT_LO +: 4];
						lock_nxt  = sr_byte_r[SB_LOCK];
						latch_nxt = 1'b0;
					end
				end
				OPC_SECT_ERASE: req_nxt = '{1'b1, OP_SECT, addr_r & ~SECT_MASK, 9'h000};
				OPC_HALF_ERASE: req_nxt = '{1'b1, OP_HALF, addr_r & ~HALF_MASK, 9'h000};
				OPC_BLOCK_ERASE: req_nxt = '{1'b1, OP_BLOCK, addr_r & ~BLOCK_MASK, 9'h000};
				OPC_CHIP_ERASE: req_nxt = '{1'b1, OP_CHIP, 24'h00_0000, 9'h000};
				default: ;
			endcase
			if (req_nxt.valid) begin
				latch_nxt = 1'b0;
			end
		end else if (commit && state_r == ST_WDATA && latch_r && !pending
		             && pcnt_r != 9'h000) begin
			req_nxt   = '{1'b1, OP_PROG, addr_r, pcnt_r};
			latch_nxt = 1'b0;
		end
	end

	// ============================================================
	// Registers
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_r   <= ST_CMD;
			lw_r      <= LW_ONE;
			txw_r     <= LW_ONE;
			quad_r    <= 1'b0;
			bit_r     <= 4'h0;
			acnt_r    <= 2'h0;
			addr_r    <= 24'h00_0000;
			rx_r      <= 8'h00;
			cmd_r     <= 8'h00;
			dcnt_r    <= 4'h0;
			pcnt_r    <= 9'h000;
			sr_byte_r <= 8'h00;
			srok_r    <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			lw_r      <= lw_nxt;
			txw_r     <= txw_nxt;
			quad_r    <= quad_nxt;
			bit_r     <= bit_nxt;
			acnt_r    <= acnt_nxt;
			addr_r    <= addr_nxt;
			rx_r      <= rx_nxt;
			cmd_r     <= cmd_nxt;
			dcnt_r    <= dcnt_nxt;
			pcnt_r    <= pcnt_nxt;
			sr_byte_r <= sr_byte_nxt;
			srok_r    <= srok_nxt;
		end
	end

	// Protection state and core outputs
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			latch_r     <= 1'b0;
			prot_r      <= 4'h0;
			lock_r      <= 1'b0;
			o_req_r     <= '0;
			o_prog_r    <= '0;
			o_rd_addr_r <= 24'h00_0000;
		end else begin
			latch_r     <= latch_nxt;
			prot_r      <= prot_nxt;
			lock_r      <= lock_nxt;
			o_req_r     <= req_nxt;
			o_prog_r    <= prog_nxt;
			o_rd_addr_r <= rd_addr_nxt;
		end
	end

	// Power-up arming on the first select fall
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			armed_r <= 1'b0;
		end else if (sel_fall) begin
			armed_r <= 1'b1;
		end
	end

	// ============================================================
	// Software register port
	logic [31:0] rd_mux; // Selected read word
	assign rd_mux = (i_reg.addr == REG_STATUS) ? {20'h0_0000, state_r, status_byte} :
	                (i_reg.addr == REG_DUMMY) ? {28'h000_0000, dummy_r} : 32'h0000_0000;

	// Dummy count write; read data for one cycle only
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			dummy_r       <= DUMMY_RST;
			o_reg_rdata_r <= 32'h0000_0000;
		end else begin
			if (i_reg.wr && i_reg.addr == REG_DUMMY) begin
				dummy_r <= i_reg.wdata[3:0];
			end
			o_reg_rdata_r <= i_reg.rd ? rd_mux : 32'h0000_0000;
		end
	end

endmodule : sfp_flash_pins

// ===== verilog/sfp_pin_edge.sv
module sfp_pin_edge (
	input  wire logic i_clock,
	input  wire logic i_sys_rst,
	input  wire logic i_sclk,
	input  wire logic i_sel_n,
	output logic      o_sclk_rise,
	output logic      o_sclk_fall,
	output logic      o_sel_fall,
	output logic      o_sel_rise
);
	import sfp_pkg::*;

	logic sclk_prev_r; // Last sampled clock level
	logic sel_prev_r;  // Last sampled select; low at reset so a held-low select is no fall

	// ============================================================
	// Edge decode
	assign o_sclk_rise = i_sclk & ~sclk_prev_r;
	assign o_sclk_fall = ~i_sclk & sclk_prev_r;
	assign o_sel_fall  = ~i_sel_n & sel_prev_r;
	assign o_sel_rise  = i_sel_n & ~sel_prev_r;

	// Sample history
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sclk_prev_r <= 1'b0;
			sel_prev_r  <= 1'b0;
		end else begin
			sclk_prev_r <= i_sclk;
			sel_prev_r  <= i_sel_n;
		end
	end

endmodule : sfp_pin_edge

// ===== verilog/sfp_pkg.sv
package sfp_pkg;

	// ============================================================
	// Instruction codes
	localparam logic [7:0] OPC_LATCH_SET   = 8'h06; // write_latch_set_cmd
	localparam logic [7:0] OPC_STAT_READ   = 8'h05; // Read status byte
	localparam logic [7:0] OPC_STAT_WRITE  = 8'h01; // Write status byte
	localparam logic [7:0] OPC_READ        = 8'h03; // Plain read
	localparam logic [7:0] OPC_FAST_READ   = 8'h0B; // Read with dummy clocks
	localparam logic [7:0] OPC_DUAL_OUT_RD = 8'h3B; // Dual-output fast read
	localparam logic [7:0] OPC_DUAL_IO_RD  = 8'hBB; // Dual-lane fast read
	localparam logic [7:0] OPC_QUAD_IO_RD  = 8'hEB; // Quad-lane fast read
	localparam logic [7:0] OPC_PAGE_PROG   = 8'h02; // Page program
	localparam logic [7:0] OPC_SECT_ERASE  = 8'h20; // 4-Kbyte erase
	localparam logic [7:0] OPC_HALF_ERASE  = 8'h52; // 32-Kbyte erase
	localparam logic [7:0] OPC_BLOCK_ERASE = 8'hD8; // 64-Kbyte erase
	localparam logic [7:0] OPC_CHIP_ERASE  = 8'hC7; // Whole array erase

	// ============================================================
	// Status byte layout and erase alignment
	localparam int          SB_PENDING = 0;            // operation_pending
	localparam int          SB_LATCH   = 1;            // Write latch
	localparam int          SB_PROT_LO = 2;            // range_protect_bit0..3
	localparam int          SB_LOCK    = 7;            // status_lock
	localparam logic [23:0] SECT_MASK  = 24'h00_0FFF;  // 4-Kbyte offset bits
	localparam logic [23:0] HALF_MASK  = 24'h00_7FFF;  // 32-Kbyte offset bits
	localparam logic [23:0] BLOCK_MASK = 24'h00_FFFF;  // 64-Kbyte offset bits

	// ============================================================
	// Software register port
	localparam logic [3:0] REG_STATUS = 4'h0; // Status and state, read only
	localparam logic [3:0] REG_DUMMY  = 4'h4; // Dummy clock count
	localparam logic [3:0] DUMMY_RST  = 4'h8; // Reset dummy count

	// ============================================================
	// Types
	typedef enum logic [1:0] {
		LW_ONE  = 2'b00,
		LW_TWO  = 2'b01,
		LW_FOUR = 2'b10
	} sfp_lane_w_t;

	typedef enum logic [3:0] {
		ST_CMD    = 4'h0,
		ST_ADDR   = 4'h1,
		ST_DUMMY  = 4'h2,
		ST_RDATA  = 4'h3,
		ST_STAT   = 4'h4,
		ST_WDATA  = 4'h5,
		ST_SRDATA = 4'h6,
		ST_TAIL   = 4'h7,
		ST_IGNORE = 4'h8
	} sfp_state_t;

	typedef enum logic [2:0] {
		OP_NONE  = 3'h0,
		OP_PROG  = 3'h1,
		OP_SECT  = 3'h2,
		OP_HALF  = 3'h3,
		OP_BLOCK = 3'h4,
		OP_CHIP  = 3'h5
	} sfp_op_t;

	typedef struct packed {
		logic       sclk;  // Serial clock
		logic       sel_n; // Device select, active low
		logic [3:0] lanes; // io_lane_three..io_lane_zero inputs
	} sfp_pins_t;

	typedef struct packed {
		logic        valid;
		sfp_op_t     op;
		logic [23:0] addr;
		logic [8:0]  count;
	} sfp_req_t;

	typedef struct packed {
		logic        valid;
		logic [23:0] addr;
		logic [7:0]  data;
	} sfp_prog_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [31:0] wdata;
	} sfp_reg_req_t;

	// Bits moved per serial clock for a lane width
	function automatic logic [3:0] lane_step(input sfp_lane_w_t w);
		unique case (w)
			LW_TWO:  lane_step = 4'h2;
			LW_FOUR: lane_step = 4'h4;
			default: lane_step = 4'h1;
		endcase
	endfunction : lane_step

endpackage : sfp_pkg

// ===== verilog/sfp_tx_shift.sv
module sfp_tx_shift (
	input  wire logic                 i_clock,
	input  wire logic                 i_sys_rst,
	input  wire logic                 i_clear,
	input  wire logic                 i_fall,
	input  wire logic                 i_run,
	input  wire sfp_pkg::sfp_lane_w_t i_width,
	input  wire logic [7:0]           i_byte,
	output logic                      o_take,
	output logic [3:0]                o_lane_out_r,
	output logic [3:0]                o_lane_oe_n_r
);
	import sfp_pkg::*;

	logic [7:0] sh_r;   // Bits not yet driven
	logic [3:0] left_r; // Count of bits left in sh_r
	logic       empty;  // Need a fresh byte
	logic [7:0] src;    // Byte the next bits come from
	logic [3:0] step;   // Bits per falling edge
	logic [3:0] lanes;  // Bits placed on lanes
	logic [3:0] mask_n; // Enables, low where driven

	// ============================================================
	// Lane mapping, most significant bit first
	assign empty  = (left_r == 4'h0);
	assign src    = empty ? i_byte : sh_r;
	assign step   = lane_step(i_width);
	assign o_take = i_fall & i_run & empty;
	assign lanes  = (i_width == LW_FOUR) ? src[7:4] :
	                (i_width == LW_TWO) ? {2'b00, src[7:6]} : {2'b00, src[7], 1'b0};
	assign mask_n = (i_width == LW_FOUR) ? 4'h0 :
	                (i_width == LW_TWO) ? 4'hC : 4'hD;

	// Drive on the serial clock's falling edge only
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sh_r          <= 8'h00;
			left_r        <= 4'h0;
			o_lane_out_r  <= 4'h0;
			o_lane_oe_n_r <= 4'hF;
		end else if (i_clear) begin
			sh_r          <= 8'h00;
			left_r        <= 4'h0;
			o_lane_out_r  <= 4'h0;
			o_lane_oe_n_r <= 4'hF;
		end else if (!i_run) begin
			o_lane_oe_n_r <= 4'hF;
		end else if (i_fall) begin
			o_lane_out_r  <= lanes;
			o_lane_oe_n_r <= mask_n;
			sh_r          <= src << step;
			left_r        <= (empty ? 4'h8 : left_r) - step;
		end
	end

endmodule : sfp_tx_shift
